// ### verilog/sdpci_cfg.svh
`ifndef SDPCI_CFG_SVH
`define SDPCI_CFG_SVH
// command codes: {cs_n, ras_n, cas_n, we_n}
`define SDPCI_CMD_DESEL    4'h8
`define SDPCI_CMD_NOP      4'h7
`define SDPCI_CMD_ACTIVE   4'h3
`define SDPCI_CMD_READ     4'h5
`define SDPCI_CMD_WRITE    4'h4
`define SDPCI_CMD_BST      4'h6
`define SDPCI_CMD_PRE      4'h2
`define SDPCI_CMD_REF      4'h1
`define SDPCI_CMD_LMR      4'h0
// address bit that selects auto/all-bank precharge
`define SDPCI_AP_BIT       10
// read mask to high-z latency in clocks
`define SDPCI_MASK_LAT     2
// column width in x16 configuration
`define SDPCI_COL_W        10
// fixed burst length loaded on each access and burst counter width
`define SDPCI_BL_RST       4'h8
`define SDPCI_BL_W         4
// read data latency in clocks
`define SDPCI_RD_LAT       2
`endif

// ### verilog/sdpci_pkg.sv
package sdpci_pkg;
  typedef enum logic [1:0] {
    SDPCI_PW_RUN,
    SDPCI_PW_PDN,
    SDPCI_PW_SREF,
    SDPCI_PW_SUSP
  } sdpci_pwr_e;
endpackage

// ### verilog/sdpci_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdpci_if #(
  parameter int DQ_W   = 32,
  parameter int ADDR_W = 14
) (
  input wire logic ref_clk_i
);
  logic                clk_en;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [1:0]          bank_sel;
  logic [ADDR_W-1:0]   addr;
  logic [DQ_W/8-1:0]   byte_mask;
  logic [DQ_W-1:0]     dq_ctl_o;
  logic [DQ_W/8-1:0]   dq_ctl_oe;
  logic [DQ_W-1:0]     dq_mem_o;
  logic [DQ_W/8-1:0]   dq_mem_oe;
  logic [DQ_W-1:0]     dq_bus;
  // resolved data bus seen by both ends
  always_comb begin
    for (int i = 0; i < DQ_W; i++) begin
      if (dq_mem_oe[i/8])
        dq_bus[i] = dq_mem_o[i];
      else if (dq_ctl_oe[i/8])
        dq_bus[i] = dq_ctl_o[i];
      else
        dq_bus[i] = 1'b0;
    end
  end
  modport mem (
    input  ref_clk_i, clk_en, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
           byte_mask, dq_bus,
    output dq_mem_o, dq_mem_oe
  );
  modport ctl (
    input  ref_clk_i, dq_bus,
    output clk_en, cs_n, ras_n, cas_n, we_n, bank_sel, addr, byte_mask,
           dq_ctl_o, dq_ctl_oe
  );
endinterface
`default_nettype wire

// ### verilog/sdpci_mem.sv
// Notes on behaviour
// - inputs captured on rising clock only
// - clock advances burst counter, output registers
// - clock gate high runs, low selects state
// - gate registered except wake, which takes the pin unregistered at the clock edge
// - input buffers off in low power
// - chip select high masks every command
// - four strobes form command code
// - high write mask keeps stored byte
// - mask bit n governs byte lane n
// - generic mask behaviour same every lane
// - bank select names target bank
// - precharge with bit ten ignores bank
// - row on activate, column on access
// - bit ten selects auto precharge
// - precharge bit ten: all or one
// - mode settings taken from address bus
// - high mask governs upper byte x16
// - data bus bidirectional, memory drives reads
`include "sdpci_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdpci_mem #(
  parameter int DQ_W   = 32,
  parameter int ADDR_W = 14,
  parameter int COL_W  = `SDPCI_COL_W,
  parameter int DEPTH  = 64
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // link
  sdpci_if.mem     link,
  // status
  output logic [1:0]  pwr_state_o,
  output logic [3:0]  bank_open_o,
  output logic [3:0]  auto_pre_o
);
  localparam int NB = DQ_W / 8;
  localparam int AW = $clog2(DEPTH);

  logic                     cke_ff;
  logic [3:0]               cmd_ff;
  logic [1:0]               ba_ff;
  logic [ADDR_W-1:0]        a_ff;
  logic [NB-1:0]            dqm_ff;
  logic [DQ_W-1:0]          dq_ff;
  logic [NB-1:0]            dqm_d1_ff;
  logic [3:0]               open_ff;
  logic [3:0]               ap_ff;
  logic [ADDR_W-1:0]        row_ff [4];
  logic [ADDR_W-1:0]        mode_ff;
  logic [COL_W-1:0]         col_ff;
  logic [1:0]               bank_ff;
  logic [`SDPCI_BL_W-1:0]   burst_cnt_ff;
  logic                     rd_ff;
  logic                     wr_ff;
  logic [`SDPCI_RD_LAT-1:0] rd_pipe_ff;
  logic [DQ_W-1:0]          dq_out_ff;
  logic [NB-1:0]            dq_oe_ff;
  wire  [DQ_W-1:0]          rd_word;
  logic [DQ_W-1:0]          rd_word_ff;
  sdpci_pkg::sdpci_pwr_e    pwr_ff;
  logic                     run;
  logic                     wake;
  logic [AW-1:0]            waddr;
  logic [3:0]               cmd;

  // pins are registered once on the rising edge; the gate is not
  // blocked so low-power exit stays possible
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cke_ff <= 1'b0;
    end else begin
      cke_ff <= link.clk_en;
    end
  end

  // power-down and self refresh watch the wake gate path only, suspend watches cke_ff; other buffers off
  assign wake = link.clk_en;
  assign run  = (pwr_ff == sdpci_pkg::SDPCI_PW_RUN) && cke_ff;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_ff <= `SDPCI_CMD_DESEL;
      ba_ff  <= 2'h0;
      a_ff   <= '0;
      dqm_ff <= '0;
      dq_ff  <= '0;
    end else if (pwr_ff == sdpci_pkg::SDPCI_PW_RUN) begin
      cmd_ff <= {link.cs_n, link.ras_n, link.cas_n, link.we_n};
      ba_ff  <= link.bank_sel;
      a_ff   <= link.addr;
      dqm_ff <= link.byte_mask;
      dq_ff  <= link.dq_bus;
    end else begin
      cmd_ff <= `SDPCI_CMD_DESEL;
    end
  end

  // chip select high decodes as deselect whatever the strobes say
  assign cmd = (cmd_ff[3] || !run) ? `SDPCI_CMD_DESEL : cmd_ff;

  // power state follows gate, burst activity and a refresh command
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_ff <= sdpci_pkg::SDPCI_PW_RUN;
    end else begin
      case (pwr_ff)
        sdpci_pkg::SDPCI_PW_RUN: begin
          if (!cke_ff && (rd_ff || wr_ff))
            pwr_ff <= sdpci_pkg::SDPCI_PW_SUSP;
          else if (!cke_ff && cmd_ff == `SDPCI_CMD_REF)
            pwr_ff <= sdpci_pkg::SDPCI_PW_SREF;
          else if (!cke_ff)
            pwr_ff <= sdpci_pkg::SDPCI_PW_PDN;
        end
        sdpci_pkg::SDPCI_PW_SUSP: begin
          if (cke_ff)
            pwr_ff <= sdpci_pkg::SDPCI_PW_RUN; // synchronous exit
        end
        default: begin
          if (wake)
            pwr_ff <= sdpci_pkg::SDPCI_PW_RUN;
        end
      endcase
    end
  end

  // bank rows, auto precharge flags, mode register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      open_ff <= 4'h0;
      ap_ff   <= 4'h0;
      mode_ff <= '0;
      for (int b = 0; b < 4; b++) row_ff[b] <= '0;
    end else begin
      case (cmd)
        `SDPCI_CMD_ACTIVE: begin
          open_ff[ba_ff] <= 1'b1;
          row_ff[ba_ff]  <= a_ff;
        end
        `SDPCI_CMD_PRE: begin
          if (a_ff[`SDPCI_AP_BIT])
            open_ff <= 4'h0;
          else
            open_ff[ba_ff] <= 1'b0;
        end
        `SDPCI_CMD_READ, `SDPCI_CMD_WRITE: begin
          ap_ff[ba_ff] <= a_ff[`SDPCI_AP_BIT];
        end
        `SDPCI_CMD_LMR: begin
          mode_ff <= a_ff;
        end
        default: begin
        end
      endcase
      // auto precharge closes the bank when its burst ends
      if ((rd_ff || wr_ff) && burst_cnt_ff == 4'h1 && ap_ff[bank_ff]) begin
        open_ff[bank_ff] <= 1'b0;
        ap_ff[bank_ff]   <= 1'b0;
      end
    end
  end

  // burst counter; stalls in clock suspend
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ff        <= 1'b0;
      wr_ff        <= 1'b0;
      col_ff       <= '0;
      bank_ff      <= 2'h0;
      burst_cnt_ff <= '0;
    end else if (cmd == `SDPCI_CMD_READ || cmd == `SDPCI_CMD_WRITE) begin
      rd_ff        <= (cmd == `SDPCI_CMD_READ);
      wr_ff        <= (cmd == `SDPCI_CMD_WRITE);
      col_ff       <= a_ff[COL_W-1:0];
      bank_ff      <= ba_ff;
      burst_cnt_ff <= `SDPCI_BL_RST;
    end else if (cmd == `SDPCI_CMD_BST || cmd == `SDPCI_CMD_PRE) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else if (run && (rd_ff || wr_ff)) begin
      col_ff       <= col_ff + 1'b1;
      burst_cnt_ff <= burst_cnt_ff - 1'b1;
      if (burst_cnt_ff == 4'h1) begin
        rd_ff <= 1'b0;
        wr_ff <= 1'b0;
      end
    end
  end

  // bank kept in the top bits; small model folds the upper columns
  assign waddr = {bank_ff, col_ff[AW-3:0]};

  // storage split per lane so each array has a single writer
  generate
    for (genvar g = 0; g < NB; g++) begin : g_lane
      logic [7:0] lane_mem [DEPTH];
      always_ff @(posedge ref_clk_i) begin
        if (wr_ff && run && !dqm_ff[g])
          lane_mem[waddr] <= dq_ff[g*8 +: 8];
      end
      assign rd_word[g*8 +: 8] = lane_mem[waddr];
    end
  endgenerate

  // read output registers and masked enables
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pipe_ff <= '0;
      dq_out_ff  <= '0;
      dq_oe_ff   <= '0;
      dqm_d1_ff  <= '0;
      rd_word_ff <= '0;
    end else if (run) begin
      rd_pipe_ff <= {rd_pipe_ff[`SDPCI_RD_LAT-2:0], rd_ff};
      dqm_d1_ff  <= dqm_ff;
      rd_word_ff <= rd_word; // extra stage lines first column up with oe
      dq_out_ff  <= rd_word_ff;
      dq_oe_ff   <= {NB{rd_pipe_ff[`SDPCI_RD_LAT-2]}} & ~dqm_d1_ff;
    end
  end

  assign link.dq_mem_o  = dq_out_ff;
  assign link.dq_mem_oe = dq_oe_ff;

  // status outputs
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_state_o <= 2'h0;
      bank_open_o <= 4'h0;
      auto_pre_o  <= 4'h0;
    end else begin
      pwr_state_o <= pwr_ff;
      bank_open_o <= open_ff;
      auto_pre_o  <= ap_ff;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sdpci_ctl.sv
`include "sdpci_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdpci_ctl #(
  parameter int DQ_W   = 32,
  parameter int ADDR_W = 14
) (
  // clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 reset_n_i,
  // user request
  input wire logic                 req_i,
  input wire logic [3:0]           req_cmd_i,
  input wire logic [1:0]           req_bank_i,
  input wire logic [ADDR_W-1:0]    req_addr_i,
  input wire logic [DQ_W/8-1:0]    req_mask_i,
  input wire logic [DQ_W-1:0]      req_wdata_i,
  input wire logic                 req_drive_i,
  input wire logic                 clk_en_i,
  // user answer
  output logic [DQ_W-1:0]          rdata_o,
  // link
  sdpci_if.ctl                     link
);
  logic [3:0]            cmd_ff;
  logic [1:0]            ba_ff;
  logic [ADDR_W-1:0]     a_ff;
  logic [DQ_W/8-1:0]     dqm_ff;
  logic [DQ_W-1:0]       wd_ff;
  logic [DQ_W/8-1:0]     oe_ff;
  logic                  cke_ff;
  logic [DQ_W-1:0]       rd_s1_ff;

  // idle cycles drive a no-op so nothing is decoded by accident
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_ff <= `SDPCI_CMD_DESEL;
      ba_ff  <= 2'h0;
      a_ff   <= '0;
      dqm_ff <= '0;
      wd_ff  <= '0;
      oe_ff  <= '0;
      cke_ff <= 1'b0;
    end else begin
      cke_ff <= clk_en_i;
      cmd_ff <= req_i ? req_cmd_i : `SDPCI_CMD_NOP;
      ba_ff  <= req_bank_i;
      a_ff   <= req_addr_i;
      dqm_ff <= req_mask_i;
      wd_ff  <= req_wdata_i;
      oe_ff  <= {(DQ_W/8){req_drive_i}};
    end
  end

  assign link.clk_en    = cke_ff;
  assign link.cs_n      = cmd_ff[3];
  assign link.ras_n     = cmd_ff[2];
  assign link.cas_n     = cmd_ff[1];
  assign link.we_n      = cmd_ff[0];
  assign link.bank_sel  = ba_ff;
  assign link.addr      = a_ff;
  assign link.byte_mask = dqm_ff;
  assign link.dq_ctl_o  = wd_ff;
  assign link.dq_ctl_oe = oe_ff;

  // read data through two flops, matching pin practice
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_s1_ff <= '0;
      rdata_o  <= '0;
    end else begin
      rd_s1_ff <= link.dq_bus;
      rdata_o  <= rd_s1_ff;
    end
  end
endmodule
`default_nettype wire

// ### dv/sdpci_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdpci_link_checker #(
  parameter int DQ_W = 32
) (
  // clock and reset
  input wire logic              ref_clk_i,
  input wire logic              reset_n_i,
  // link pins
  input wire logic              clk_en,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [DQ_W/8-1:0] byte_mask,
  input wire logic [DQ_W/8-1:0] dq_ctl_oe,
  input wire logic [DQ_W/8-1:0] dq_mem_oe
);
  logic       rd_cmd;
  logic       wr_cmd;
  logic [7:0] rd_age_ff;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // commands as the memory registers them; gated clock hides them
  assign rd_cmd = clk_en & !cs_n & ras_n & !cas_n & we_n;
  assign wr_cmd = clk_en & !cs_n & ras_n & !cas_n & !we_n;
  // saturating age of the last read, bounds when output drive is legal
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      rd_age_ff <= 8'hFF;
    else if (rd_cmd)
      rd_age_ff <= 8'h00;
    else if (rd_age_ff != 8'hFF)
      rd_age_ff <= rd_age_ff + 8'h01;
  end
  AST_RST_DESEL: assert property ($rose(reset_n_i) |-> cs_n && !clk_en)
    else $error("link not idle after reset");
  AST_RD_ONLY: assert property (|dq_mem_oe |-> rd_age_ff <= 8'h14)
    else $error("memory drives without a read");
  AST_RD_ANSWER: assert property (
    rd_cmd && byte_mask == '0 |-> ##[1:10] &dq_mem_oe)
    else $error("read not answered");
  AST_OE_BURST: assert property (
    $rose(&dq_mem_oe) && byte_mask == '0 |-> (&dq_mem_oe) [*8])
    else $error("read burst cut short");
  AST_MASK_HIZ: assert property (
    (dq_mem_oe & $past(byte_mask, 3) & $past(byte_mask, 4)) == '0)
    else $error("masked lane still driven");
  AST_MASK_LANE: assert property (
    |dq_mem_oe && $past(byte_mask, 3) == $past(byte_mask, 4)
    |-> dq_mem_oe == ~$past(byte_mask, 3))
    else $error("lane enables do not follow mask");
  AST_NO_FIGHT: assert property ((dq_mem_oe & dq_ctl_oe) == '0)
    else $error("both ends drive data");
  AST_WR_NO_DRIVE: assert property (
    wr_cmd && rd_age_ff > 8'h14 |-> (dq_mem_oe == '0) [*4])
    else $error("memory drives during write");
  // main scenarios reached
  cover property (&dq_mem_oe);
  cover property (|dq_mem_oe && !(&dq_mem_oe));
  cover property (wr_cmd);
  cover property (!clk_en ##1 !clk_en);
endmodule
`default_nettype wire

// ### dv/sdram_pin_command_interface_tb.sv
`include "sdpci_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_command_interface_tb;
  typedef struct {
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [13:0] addr;
    logic [3:0]  mask;
    logic [31:0] wdata;
    logic        chk;
    logic [3:0]  open;
  } sdpci_row_s;
  logic        ref_clk;
  logic        reset_n;
  logic        req;
  logic [3:0]  req_cmd;
  logic [1:0]  req_bank;
  logic [13:0] req_addr;
  logic [3:0]  req_mask;
  logic [31:0] req_wdata;
  logic        req_drive;
  logic        clk_en;
  logic [31:0] rdata;
  logic [1:0]  pwr_state;
  logic [3:0]  bank_open;
  logic [3:0]  auto_pre;
  logic        seen;
  logic [3:0]  got_oe;
  logic [3:0]  got_ap;
  logic [31:0] got;
  logic [31:0] got_rd;
  int          miscompares;
  int          n_compared;
  sdpci_row_s  rows [15];

  sdpci_if link (.ref_clk_i(ref_clk));
  sdpci_ctl sdpci_ctl_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .req_i(req), .req_cmd_i(req_cmd), .req_bank_i(req_bank),
    .req_addr_i(req_addr), .req_mask_i(req_mask), .req_wdata_i(req_wdata),
    .req_drive_i(req_drive), .clk_en_i(clk_en), .rdata_o(rdata),
    .link(link.ctl));
  sdpci_mem sdpci_mem_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .link(link.mem), .pwr_state_o(pwr_state), .bank_open_o(bank_open),
    .auto_pre_o(auto_pre));
  sdpci_link_checker link_chk (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .clk_en(link.clk_en), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .byte_mask(link.byte_mask),
    .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));

  task automatic chk_state(input logic [3:0] g, input logic [3:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("TB: %0d compared, %0d miscompares", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one command, then no-ops that keep mask and data so bursts see them
  task automatic op(input sdpci_row_s r);
    int k;
    seen = 1'b0;
    k = 99;
    @(posedge ref_clk);
    req       <= 1'b1;
    req_cmd   <= r.cmd;
    req_bank  <= r.bank;
    req_addr  <= r.addr;
    req_mask  <= r.mask;
    req_wdata <= r.wdata;
    req_drive <= (r.cmd == `SDPCI_CMD_WRITE);
    @(posedge ref_clk);
    req_cmd <= `SDPCI_CMD_NOP;
    #1 chk_state({link.cs_n, link.ras_n, link.cas_n, link.we_n}, r.cmd);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      #1;
      if (!seen && |link.dq_mem_oe) begin
        seen = 1'b1;
        got_oe = link.dq_mem_oe;
        got_ap = auto_pre;
        got = link.dq_bus;
        k = i;
      end
      if (i == k + 3)
        got_rd = rdata;
    end
    @(posedge ref_clk);
    req <= 1'b0;
    req_drive <= 1'b0;
  endtask

  // 200 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    req = 1'b0;
    req_cmd = `SDPCI_CMD_NOP;
    req_bank = 2'h0;
    req_addr = 14'h0000;
    req_mask = 4'h0;
    req_wdata = 32'h0000_0000;
    req_drive = 1'b0;
    clk_en = 1'b0;
    miscompares = 0;
    n_compared = 0;
    rows = '{
      '{`SDPCI_CMD_LMR, 2'h0, 14'h0033, 4'h0, 32'h0, 1'b0, 4'h0},
      '{`SDPCI_CMD_ACTIVE, 2'h0, 14'h0005, 4'h0, 32'h0, 1'b0, 4'h1},
      '{`SDPCI_CMD_ACTIVE, 2'h1, 14'h0005, 4'h0, 32'h0, 1'b0, 4'h3},
      '{`SDPCI_CMD_WRITE, 2'h0, 14'h0004, 4'h0, 32'hA5A5_5AC3, 1'b0, 4'h3},
      '{`SDPCI_CMD_WRITE, 2'h1, 14'h0004, 4'h0, 32'h1234_5678, 1'b0, 4'h3},
      '{`SDPCI_CMD_WRITE, 2'h0, 14'h0004, 4'h2, 32'hFFFF_FFFF, 1'b0, 4'h3},
      '{`SDPCI_CMD_READ, 2'h0, 14'h0004, 4'h0, 32'hFFFF_5AFF, 1'b1, 4'h3},
      '{`SDPCI_CMD_READ, 2'h1, 14'h0004, 4'h4, 32'h1200_5678, 1'b1, 4'h3},
      '{4'hD, 2'h0, 14'h0004, 4'h0, 32'h0, 1'b0, 4'h3},
      '{`SDPCI_CMD_BST, 2'h0, 14'h0000, 4'h0, 32'h0, 1'b0, 4'h3},
      '{`SDPCI_CMD_PRE, 2'h1, 14'h0000, 4'h0, 32'h0, 1'b0, 4'h1},
      '{`SDPCI_CMD_READ, 2'h0, 14'h0404, 4'h0, 32'hFFFF_5AFF, 1'b1, 4'h0},
      '{`SDPCI_CMD_ACTIVE, 2'h2, 14'h0005, 4'h0, 32'h0, 1'b0, 4'h4},
      '{`SDPCI_CMD_PRE, 2'h1, 14'h0400, 4'h0, 32'h0, 1'b0, 4'h0},
      '{`SDPCI_CMD_REF, 2'h0, 14'h0000, 4'h0, 32'h0, 1'b0, 4'h0}};
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    clk_en <= 1'b1;
    // table of ordinary commands
    foreach (rows[i]) begin
      op(rows[i]);
      chk_state(bank_open, rows[i].open);
      chk_state({3'h0, seen}, {3'h0, rows[i].chk});
      if (rows[i].chk) begin
        chk_state(got_oe, ~rows[i].mask);
        chk_state(got_ap, (4'h1 << rows[i].bank) & {4{rows[i].addr[10]}});
        chk_data(got, rows[i].wdata);
        chk_data(got_rd, rows[i].wdata);
      end
      $display("TB: row %0d done", i);
    end
    // gate the clock with banks idle, then try to open a bank
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 chk_state({2'h0, pwr_state}, {2'h0, sdpci_pkg::SDPCI_PW_PDN});
    op('{`SDPCI_CMD_ACTIVE, 2'h3, 14'h0001, 4'h0, 32'h0, 1'b0, 4'h0});
    chk_state(bank_open, 4'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk_state({2'h0, pwr_state}, {2'h0, sdpci_pkg::SDPCI_PW_RUN});
    $display("TB: power test done");
    // reset in mid-run with a bank open
    op('{`SDPCI_CMD_ACTIVE, 2'h1, 14'h0001, 4'h0, 32'h0, 1'b0, 4'h0});
    chk_state(bank_open, 4'h2);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk_state(bank_open, 4'h0);
    chk_state({2'h0, link.cs_n, link.clk_en}, 4'h2);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("TB: reset test done");
    close_out();
  end
endmodule
`default_nettype wire
